// ### rtl/lis_pkg.sv
`default_nettype none
package lis_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 40000;
	localparam int AUTO_INIT_TIME_PS = 2000000;
	localparam int AUTO_INIT_MAX_TIME_PS = 10000000;
	localparam int ZQ_INIT_TIME_PS = 1000000;
	localparam int AUTO_INIT_CYC = AUTO_INIT_TIME_PS / CLK_PERIOD_PS;
	localparam int AUTO_INIT_MAX_CYC = AUTO_INIT_MAX_TIME_PS / CLK_PERIOD_PS;
	localparam int ZQ_INIT_CYC = (ZQ_INIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ------------------------------------------------------------
	// mode register addresses and fields
	// ------------------------------------------------------------
	localparam logic [7:0] MR_INFO = 8'h00;
	localparam logic [7:0] MR_FEAT1 = 8'h01;
	localparam logic [7:0] MR_FEAT2 = 8'h02;
	localparam logic [7:0] MR_IOCFG = 8'h03;
	localparam logic [7:0] MR_ZQCAL = 8'h0a;
	localparam logic [7:0] MR_RESET = 8'h3f;
	localparam int BIT_AUTO_INIT = 0;
	localparam int BIT_RZQ_LO = 3;
	localparam logic [7:0] RST_FEAT = 8'h00;
	// ------------------------------------------------------------
	// states and commands
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_NOP,
		CMD_MRW,
		CMD_MRR,
		CMD_OTHER
	} lis_cmd_t;
	typedef enum {
		ST_POWER_UP,
		ST_AUTO_INIT,
		ST_WAIT_ZQ,
		ST_ZQ_CAL,
		ST_IDLE
	} lis_state_t;
endpackage
`default_nettype wire

// ### rtl/lis_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lis_mode_regs (
	// clock
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	// write port
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [7:0] wr_data,
	// read port
	input wire logic [1:0] rd_sel,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:3];

	// ------------------------------------------------------------
	// storage for feature registers one to three
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < 4; i++) begin
				mem[i] <= lis_pkg::RST_FEAT;
			end
		end else if (clk_en && wr_en) begin
			mem[wr_sel] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data <= lis_pkg::RST_FEAT;
		end else if (clk_en) begin
			rd_data <= mem[rd_sel];
		end
	end
endmodule
`default_nettype wire

// ### rtl/lis_init_seq.sv
`timescale 1ns/1ps
`default_nettype none
module lis_init_seq #(
	parameter int AUTO_INIT_CYC = lis_pkg::AUTO_INIT_CYC,
	parameter int ZQ_INIT_CYC = lis_pkg::ZQ_INIT_CYC,
	parameter bit RZQ_CONNECTED = 1'b1
) (
	// clock
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	// command pins
	input wire logic cke,
	input wire lis_pkg::lis_cmd_t cmd,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	// read answer
	output logic rd_valid,
	output logic [7:0] rd_data,
	// pin drive and status
	output logic dq_oe,
	output logic auto_init_status,
	output logic ext_cal_resistor_pin,
	output logic dev_ready
);
	lis_pkg::lis_state_t state;
	logic [17:0] cnt;
	logic [1:0] rz;
	logic rd_pend;
	logic rd_info;
	logic [7:0] next_info;
	logic [7:0] feat_q;
	logic wr_feat;

	assign wr_feat = cke && cmd == lis_pkg::CMD_MRW && cmd_addr >= lis_pkg::MR_FEAT1
		&& cmd_addr <= lis_pkg::MR_IOCFG && state == lis_pkg::ST_IDLE;

	lis_mode_regs u_lis_mode_regs (
		.clk_sys(clk_sys),
		.srst(srst),
		.clk_en(clk_en),
		.wr_en(wr_feat),
		.wr_sel(cmd_addr[1:0]),
		.wr_data(cmd_data),
		.rd_sel(cmd_addr[1:0]),
		.rd_data(feat_q)
	);

	// ------------------------------------------------------------
	// initialization sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= lis_pkg::ST_POWER_UP;
			cnt <= 18'h00000;
		end else if (clk_en) begin
			if (cke && cmd == lis_pkg::CMD_MRW && cmd_addr == lis_pkg::MR_RESET) begin
				state <= lis_pkg::ST_AUTO_INIT;
				cnt <= 18'h00000;
			end else begin
				unique case (state)
					lis_pkg::ST_POWER_UP: cnt <= 18'h00000;
					lis_pkg::ST_AUTO_INIT: begin
						cnt <= cnt + 18'h00001;
						if (cnt >= 18'(AUTO_INIT_CYC - 1)) begin
							state <= lis_pkg::ST_WAIT_ZQ;
						end
					end
					lis_pkg::ST_WAIT_ZQ: begin
						if (cke && cmd == lis_pkg::CMD_MRW && cmd_addr == lis_pkg::MR_ZQCAL) begin
							state <= lis_pkg::ST_ZQ_CAL;
							cnt <= 18'h00000;
						end else if (cke && cmd == lis_pkg::CMD_MRW) begin
							state <= lis_pkg::ST_IDLE;
						end
					end
					lis_pkg::ST_ZQ_CAL: begin
						cnt <= cnt + 18'h00001;
						if (cnt >= 18'(ZQ_INIT_CYC - 1)) begin
							state <= lis_pkg::ST_IDLE;
						end
					end
					lis_pkg::ST_IDLE: cnt <= 18'h00000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			auto_init_status <= 1'b1;
			dev_ready <= 1'b0;
			rz <= 2'h0;
			ext_cal_resistor_pin <= 1'b0;
		end else if (clk_en) begin
			auto_init_status <= state == lis_pkg::ST_POWER_UP
				|| state == lis_pkg::ST_AUTO_INIT;
			dev_ready <= state == lis_pkg::ST_IDLE;
			if (state == lis_pkg::ST_ZQ_CAL && cnt == 18'(ZQ_INIT_CYC - 1)) begin
				rz <= RZQ_CONNECTED ? 2'h0 : 2'h1;
			end
			ext_cal_resistor_pin <= RZQ_CONNECTED;
		end
	end

	// ------------------------------------------------------------
	// mode register read path
	// ------------------------------------------------------------
	always_comb begin
		next_info = 8'h00;
		next_info[lis_pkg::BIT_AUTO_INIT] = auto_init_status;
		next_info[lis_pkg::BIT_RZQ_LO +: 2] = rz;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_pend <= 1'b0;
			rd_info <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else if (clk_en) begin
			rd_pend <= cke && cmd == lis_pkg::CMD_MRR;
			rd_info <= cmd_addr == lis_pkg::MR_INFO;
			rd_valid <= rd_pend;
			if (rd_pend) begin
				rd_data <= rd_info ? next_info : feat_q;
			end
		end
	end

	// outputs float unless cke is high and data is driven
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dq_oe <= 1'b0;
		end else if (clk_en) begin
			dq_oe <= cke && rd_pend;
		end
	end
endmodule
`default_nettype wire

// ### test/lis_init_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lis_init_seq_assertions #(
	parameter int AUTO_INIT_CYC = 5,
	parameter int ZQ_INIT_CYC = 3,
	parameter bit RZQ_CONNECTED = 1'b1
) (
	// clock
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	// command pins
	input wire logic cke,
	input wire lis_pkg::lis_cmd_t cmd,
	input wire logic [7:0] cmd_addr,
	// outputs
	input wire logic rd_valid,
	input wire logic dq_oe,
	input wire logic auto_init_status,
	input wire logic ext_cal_resistor_pin,
	input wire logic dev_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire logic go = clk_en && cke;
	wire logic mrw = go && cmd == lis_pkg::CMD_MRW;
	wire logic rst_cmd = mrw && cmd_addr == lis_pkg::MR_RESET;
	wire logic zq_cmd = mrw && cmd_addr == lis_pkg::MR_ZQCAL;
	sequence s_init_run;
		auto_init_status[*5] ##[1:250] !auto_init_status;
	endsequence
	a_oe_with_read: assert property (dq_oe |-> rd_valid && cke) else $error("oe");
	a_read_latency: assert property (go && cmd == lis_pkg::CMD_MRR ##1 clk_en |=> rd_valid)
		else $error("read late");
	a_status_clears: assert property (rst_cmd |=> ##1 s_init_run) else $error("init");
	a_reset_restart: assert property (rst_cmd ##1 clk_en |=> auto_init_status && !dev_ready)
		else $error("restart");
	a_zq_time: assert property (zq_cmd && !auto_init_status && !dev_ready
		|=> !dev_ready[*3] ##[0:3] dev_ready) else $error("zq");
	a_rzq_report: assert property (dev_ready |-> ext_cal_resistor_pin == RZQ_CONNECTED)
		else $error("rzq");
	a_status_hold: assert property (!auto_init_status && !rst_cmd && !$past(rst_cmd)
		|=> !auto_init_status) else $error("status");
	a_ready_hold: assert property (dev_ready && !rst_cmd && !$past(rst_cmd) |=> dev_ready)
		else $error("ready");
endmodule
bind lis_init_seq lis_init_seq_assertions #(.AUTO_INIT_CYC(AUTO_INIT_CYC),
	.ZQ_INIT_CYC(ZQ_INIT_CYC), .RZQ_CONNECTED(RZQ_CONNECTED)) u_lis_init_seq_assertions (
	.clk_sys, .srst, .clk_en, .cke, .cmd, .cmd_addr, .rd_valid, .dq_oe,
	.auto_init_status, .ext_cal_resistor_pin, .dev_ready);
`default_nettype wire

// ### test/lis_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lis_ctrl_model (
	// clock
	input wire logic clk_sys,
	// command pins
	output logic cke = 1'b0,
	output var lis_pkg::lis_cmd_t cmd = lis_pkg::CMD_NOP,
	output logic [7:0] cmd_addr = 8'h00,
	output logic [7:0] cmd_data = 8'h00
);
	task automatic send(input lis_pkg::lis_cmd_t c, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		cmd = c;
		cmd_addr = a;
		cmd_data = d;
		@(negedge clk_sys);
		cmd = lis_pkg::CMD_NOP;
		cmd_addr = ~a;
		cmd_data = ~d;
	endtask
	task automatic power_up();
		repeat (8) @(negedge clk_sys);
		cke = 1'b1;
		repeat (5000) @(negedge clk_sys);
		send(lis_pkg::CMD_MRW, lis_pkg::MR_RESET, 8'h00);
		repeat (25) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ### test/test_lpddr_init_power_sequence.sv
`timescale 1ns/1ps
`default_nettype none
module test_lpddr_init_power_sequence;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic cke, rd_valid, dq_oe, auto_init_status, ext_cal_resistor_pin, dev_ready;
	lis_pkg::lis_cmd_t cmd;
	logic [7:0] cmd_addr, cmd_data, rd_data;
	int num_errors = 0;
	int total_checks = 0;
	logic [7:0] rows [4][3] = '{'{8'h01, 8'h5a, 8'h5a}, '{8'h02, 8'h07, 8'h07},
		'{8'h03, 8'h02, 8'h02}, '{8'h00, 8'hff, 8'h00}};
	always #20 clk_sys = ~clk_sys;
	lis_init_seq #(.AUTO_INIT_CYC(5), .ZQ_INIT_CYC(3)) u_lis_init_seq (.clk_sys, .srst,
		.clk_en, .cke, .cmd, .cmd_addr, .cmd_data, .rd_valid, .rd_data, .dq_oe,
		.auto_init_status, .ext_cal_resistor_pin, .dev_ready);
	lis_ctrl_model u_lis_ctrl_model (.clk_sys, .cke, .cmd, .cmd_addr, .cmd_data);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic mrr(input logic [7:0] a, output logic [7:0] d);
		u_lis_ctrl_model.send(lis_pkg::CMD_MRR, a, 8'h00);
		for (int n = 0; n < 6 && rd_valid !== 1'b1; n++)
			@(negedge clk_sys);
		d = rd_valid ? rd_data : 8'hxx;
	endtask
	initial begin
		#800000;
		num_errors++;
		give_verdict();
	end
	initial begin
		logic [7:0] d;
		repeat (8) @(negedge clk_sys);
		srst = 1'b0;
		check({5'h00, dev_ready, auto_init_status, dq_oe}, 8'h02);
		u_lis_ctrl_model.power_up();
		mrr(lis_pkg::MR_INFO, d);
		check({7'h00, d[0]}, 8'h00);
		u_lis_ctrl_model.send(lis_pkg::CMD_MRW, lis_pkg::MR_ZQCAL, 8'hff);
		check({7'h00, dev_ready}, 8'h00);
		repeat (6) @(negedge clk_sys);
		check({6'h00, ext_cal_resistor_pin, dev_ready}, 8'h03);
		foreach (rows[i]) begin
			u_lis_ctrl_model.send(lis_pkg::CMD_MRW, rows[i][0], rows[i][1]);
			mrr(rows[i][0], d);
			check(d, rows[i][2]);
		end
		u_lis_ctrl_model.send(lis_pkg::CMD_MRW, lis_pkg::MR_RESET, 8'h00);
		// status levels follow the state one edge later
		@(negedge clk_sys);
		check({6'h00, auto_init_status, dev_ready}, 8'h02);
		// frozen clock enable must stretch auto-init
		clk_en = 1'b0;
		repeat (12) @(negedge clk_sys);
		check({6'h00, auto_init_status, dev_ready}, 8'h02);
		clk_en = 1'b1;
		repeat (12) @(negedge clk_sys);
		check({6'h00, auto_init_status, dev_ready}, 8'h00);
		u_lis_ctrl_model.cke = 1'b0;
		mrr(lis_pkg::MR_INFO, d);
		check({6'h00, rd_valid, dq_oe}, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
